// [src/fan_drive_modbus_register_map.sv]
// modbus holding and input register map of the fan drive with timeout, ramp and thermal supervision
// Summary of operation
// - baud register codes tenths kbps, resets 96
// - framing 0 2stop, 1 even, 2 odd
// - loop reference 0..100, active only type 12
// - three loop gains 0..32767, reset 0
// - loop period ms 0..32767, reset 0
// - speed over threshold flagged, zero disables
// - range mode limits high threshold low..max
// - silence timeout stops fan, raises alarm
// - stop holds until reset command; zero disables
// - speed reference starts at min, ramps
// - overheat derates, then stops with alarm
// - overheat alarm clears itself when cooled
// - fault codes paired in registers 10, 17
// - raw inputs report 10V/2^16 per count
// - 33 input registers, listed ones populated
// - input type 12 selects fixed-reference loop
// - output function 2 shows speed over threshold
`timescale 1ns/10ps
`include "fan_drive_regs.svh"

module fan_drive_modbus_register_map #(
  parameter int SECOND_CYCLES = `SECOND_NS / `CLK_PERIOD_NS,
  parameter int RAMP_TICK_CYCLES = `RAMP_TICK_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // decoded modbus requests from the frame engine
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_holding_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic reset_cmd_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_exc_o,
  output logic [15:0] rsp_data_o,
  // settings held elsewhere in the drive
  input wire logic [15:0] input_type_i,
  input wire logic [15:0] dout_func_i,
  input wire logic [15:0] speed_low_i,
  input wire logic [15:0] speed_max_i,
  input wire logic [15:0] speed_min_i,
  input wire logic [15:0] temp_limit_i,
  // motor control measurements and demands
  input wire logic run_i,
  input wire logic [15:0] speed_goal_i,
  input wire logic [15:0] ramp_step_i,
  input wire logic [15:0] rotor_speed_i,
  input wire logic [15:0] dc_link_i,
  input wire logic [15:0] wind_current_i,
  input wire logic [15:0] wind_voltage_i,
  input wire logic [15:0] setp_volts_i,
  input wire logic [15:0] stage_temp_i,
  input wire logic [15:0] fault_pri_i,
  input wire logic [15:0] fault_sec_i,
  input wire logic [15:0] run_raw_i,
  input wire logic [15:0] setp_raw_i,
  input wire logic [15:0] sensor_raw_i,
  input wire logic [15:0] power_i,
  input wire logic [15:0] supply_current_i,
  // settings out to the serial line and control loop
  output logic [15:0] baud_sel_o,
  output logic [15:0] framing_sel_o,
  output logic [15:0] loop_ref_o,
  output logic loop_ref_active_o,
  output logic [15:0] gain_p_o,
  output logic [15:0] gain_i_o,
  output logic [15:0] gain_d_o,
  output logic [15:0] period_ms_o,
  // supervision results
  output logic [15:0] speed_ref_o,
  output logic speed_over_o,
  output logic derate_o,
  output logic fan_stop_o,
  output logic [15:0] fault_pri_o,
  output logic [15:0] fault_sec_o,
  output logic dout_o
);

  fan_drive_pkg::state_t s_q;
  fan_drive_pkg::state_t s_d;

  // inclusive range test, used for writes and for the range output
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic wr;

  logic [16:0] ramp_up;
  logic [16:0] ramp_dn;

  always_comb begin
    s_d = s_q;
    wr = req_valid_i && req_write_i;

    ramp_up = {1'b0, s_q.speed_ref} + {1'b0, ramp_step_i};
    ramp_dn = {1'b0, s_q.speed_ref} - {1'b0, ramp_step_i};

    // answer path: one cycle after every request
    s_d.rsp_valid = req_valid_i;
    s_d.rsp_exc = `EXC_NONE;
    s_d.rsp_data = 16'h0000;

    if (req_valid_i && req_holding_i) begin
      case (req_addr_i)
        `HR_BAUD: begin
          s_d.rsp_data = s_q.baud;
          if (wr) begin
            if (req_wdata_i == `BAUD_9K6 || req_wdata_i == `BAUD_19K2 ||
                req_wdata_i == `BAUD_38K4 || req_wdata_i == `BAUD_57K6) begin
              s_d.baud = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_FRAMING: begin
          s_d.rsp_data = s_q.framing;
          if (wr) begin
            if (req_wdata_i <= `FRAMING_MAX) begin
              s_d.framing = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_LOOP_REF: begin
          s_d.rsp_data = s_q.loop_ref;
          if (wr) begin
            if (req_wdata_i <= `LOOP_REF_MAX) begin
              s_d.loop_ref = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_GAIN_P: begin
          s_d.rsp_data = s_q.gain_p;
          if (wr) begin
            if (req_wdata_i <= `GAIN_MAX) begin
              s_d.gain_p = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_GAIN_I: begin
          s_d.rsp_data = s_q.gain_i;
          if (wr) begin
            if (req_wdata_i <= `GAIN_MAX) begin
              s_d.gain_i = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_GAIN_D: begin
          s_d.rsp_data = s_q.gain_d;
          if (wr) begin
            if (req_wdata_i <= `GAIN_MAX) begin
              s_d.gain_d = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_PERIOD: begin
          s_d.rsp_data = s_q.period;
          if (wr) begin
            if (req_wdata_i <= `GAIN_MAX) begin
              s_d.period = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_SPEED_HIGH: begin
          s_d.rsp_data = s_q.speed_high;
          if (wr) begin
            // range mode needs the high limit at or above the low limit
            if (in_range(req_wdata_i, (dout_func_i == `DOUT_RANGE) ? speed_low_i : `RST_ZERO,
                         speed_max_i)) begin
              s_d.speed_high = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        `HR_SILENCE: begin
          s_d.rsp_data = s_q.silence;
          if (wr) begin
            if (req_wdata_i <= `SILENCE_MAX_S) begin
              s_d.silence = req_wdata_i;
            end else begin
              s_d.rsp_exc = `EXC_BAD_VALUE;
            end
          end
        end

        default: begin
          s_d.rsp_exc = `EXC_BAD_ADDR;
        end
      endcase
    end else if (req_valid_i) begin
      // input registers: sampled at the read itself so the answer is current
      if (wr || req_addr_i > `IR_LAST) begin
        s_d.rsp_exc = `EXC_BAD_ADDR;
      end else begin
        case (req_addr_i)
          `IR_SPEED_TARGET: s_d.rsp_data = s_q.speed_ref;
          `IR_ROTOR_SPEED: s_d.rsp_data = rotor_speed_i;
          `IR_DC_LINK: s_d.rsp_data = dc_link_i;
          `IR_FAULT_PRI: s_d.rsp_data = s_q.fault_pri;
          `IR_WIND_CURRENT: s_d.rsp_data = wind_current_i;
          `IR_WIND_VOLTAGE: s_d.rsp_data = wind_voltage_i;
          `IR_SETP_VOLTS: s_d.rsp_data = setp_volts_i;
          `IR_STAGE_TEMP: s_d.rsp_data = stage_temp_i;
          `IR_FAULT_SEC: s_d.rsp_data = s_q.fault_sec;
          `IR_RUN_RAW: s_d.rsp_data = run_raw_i;
          `IR_SETP_RAW: s_d.rsp_data = setp_raw_i;
          `IR_SENSOR_RAW: s_d.rsp_data = sensor_raw_i;
          `IR_POWER: s_d.rsp_data = power_i;
          `IR_SUPPLY_CUR: s_d.rsp_data = supply_current_i;
          default: s_d.rsp_data = 16'h0000;
        endcase
      end
    end

    // one-second time base, restarted by any traffic
    s_d.sec_tick = 1'b0;
    if (req_valid_i) begin
      s_d.sec_cnt = 24'h00_0000;
      s_d.silence_cnt = 16'h0000;
    end else if (s_q.sec_cnt == 24'(SECOND_CYCLES - 1)) begin
      s_d.sec_cnt = 24'h00_0000;
      s_d.sec_tick = 1'b1;
    end else begin
      s_d.sec_cnt = s_q.sec_cnt + 24'h00_0001;
    end

    // silence timeout: set wins over the reset command in the same cycle
    if (reset_cmd_i) begin
      s_d.link_lost = 1'b0;
    end
    if (s_q.sec_tick && s_q.silence != `RST_ZERO && !req_valid_i) begin
      s_d.silence_cnt = s_q.silence_cnt + 16'h0001;
      if (s_q.silence_cnt + 16'h0001 >= s_q.silence) begin
        s_d.link_lost = 1'b1;
      end
    end

    // thermal derating then stop; cooled module clears derating, its count and the thermal stop by itself
    if (stage_temp_i > temp_limit_i) begin
      s_d.derate = 1'b1;
      if (s_q.sec_tick && !s_q.overtemp) begin
        s_d.derate_sec = s_q.derate_sec + 16'h0001;
        if (s_q.derate_sec + 16'h0001 >= `DERATE_LIMIT_S) begin
          s_d.overtemp = 1'b1;
        end
      end
    end else if (stage_temp_i < temp_limit_i) begin
      s_d.derate = 1'b0;
      s_d.derate_sec = 16'h0000;
      s_d.overtemp = 1'b0;
    end

    s_d.fan_stop = s_d.link_lost || s_d.overtemp;

    // speed reference ramp on a millisecond tick
    if (s_q.ms_cnt == 16'(RAMP_TICK_CYCLES - 1)) begin
      s_d.ms_cnt = 16'h0000;
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
    end

    case (s_q.ramp)
      fan_drive_pkg::RAMP_IDLE: begin
        s_d.speed_ref = 16'h0000;
        if (run_i && !s_q.fan_stop) begin
          s_d.speed_ref = speed_min_i;
          s_d.ramp = fan_drive_pkg::RAMP_RUN;
        end
      end

      fan_drive_pkg::RAMP_RUN: begin
        if (!run_i || s_q.fan_stop) begin
          s_d.speed_ref = 16'h0000;
          s_d.ramp = fan_drive_pkg::RAMP_IDLE;
        end else if (s_q.ms_cnt == 16'(RAMP_TICK_CYCLES - 1)) begin
          // clamp so the step never overshoots the goal
          if (s_q.speed_ref < speed_goal_i) begin
            s_d.speed_ref = (ramp_up >= {1'b0, speed_goal_i}) ? speed_goal_i : ramp_up[15:0];
          end else if (s_q.speed_ref > speed_goal_i) begin
            s_d.speed_ref = (ramp_dn[16] || ramp_dn[15:0] <= speed_goal_i) ? speed_goal_i : ramp_dn[15:0];
          end
        end
      end
      default: begin
        s_d.ramp = fan_drive_pkg::RAMP_IDLE;
      end
    endcase

    s_d.speed_over = (s_q.speed_high != `RST_ZERO) && (rotor_speed_i > s_q.speed_high);

    s_d.loop_ref_active = (input_type_i == `INPUT_TYPE_PID_FIXED);

    // own faults override the pair reported by the motor control
    if (s_d.link_lost) begin
      s_d.fault_pri = `FAULT_PRI_AUTO;
      s_d.fault_sec = `FAULT_SEC_LINK_LOST;
    end else if (s_d.overtemp) begin
      s_d.fault_pri = `FAULT_PRI_AUTO;
      s_d.fault_sec = `FAULT_SEC_OVERTEMP;
    end else begin
      s_d.fault_pri = fault_pri_i;
      s_d.fault_sec = fault_sec_i;
    end

    case (dout_func_i)
      `DOUT_ALARM: s_d.dout = (s_d.fault_pri != `RST_ZERO);
      `DOUT_THRESHOLD: s_d.dout = s_d.speed_over;
      `DOUT_RANGE: s_d.dout = in_range(rotor_speed_i, speed_low_i, s_q.speed_high);
      default: s_d.dout = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.baud <= `RST_BAUD;
      s_q.ramp <= fan_drive_pkg::RAMP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid_o = s_q.rsp_valid;
  assign rsp_exc_o = s_q.rsp_exc;
  assign rsp_data_o = s_q.rsp_data;

  assign baud_sel_o = s_q.baud;
  assign framing_sel_o = s_q.framing;
  assign loop_ref_o = s_q.loop_ref;
  assign loop_ref_active_o = s_q.loop_ref_active;
  assign gain_p_o = s_q.gain_p;
  assign gain_i_o = s_q.gain_i;
  assign gain_d_o = s_q.gain_d;
  assign period_ms_o = s_q.period;

  assign speed_ref_o = s_q.speed_ref;
  assign speed_over_o = s_q.speed_over;
  assign derate_o = s_q.derate;
  assign fan_stop_o = s_q.fan_stop;
  assign fault_pri_o = s_q.fault_pri;
  assign fault_sec_o = s_q.fault_sec;
  assign dout_o = s_q.dout;

endmodule // fan_drive_modbus_register_map

// [src/fan_drive_regs.svh]
// register offsets, field values, reset values and timing figures of the fan drive register map
`ifndef FAN_DRIVE_REGS_SVH
`define FAN_DRIVE_REGS_SVH

// holding registers
`define HR_BAUD 16'h002F
`define HR_FRAMING 16'h0030
`define HR_LOOP_REF 16'h0032
`define HR_GAIN_P 16'h0033
`define HR_GAIN_I 16'h0034
`define HR_GAIN_D 16'h0035
`define HR_PERIOD 16'h0036
`define HR_SPEED_HIGH 16'h0037
`define HR_SILENCE 16'h0038

// input registers
`define IR_SPEED_TARGET 16'h0002
`define IR_ROTOR_SPEED 16'h0003
`define IR_DC_LINK 16'h0009
`define IR_FAULT_PRI 16'h000A
`define IR_WIND_CURRENT 16'h000C
`define IR_WIND_VOLTAGE 16'h000D
`define IR_SETP_VOLTS 16'h000E
`define IR_STAGE_TEMP 16'h000F
`define IR_FAULT_SEC 16'h0011
`define IR_RUN_RAW 16'h001C
`define IR_SETP_RAW 16'h001D
`define IR_SENSOR_RAW 16'h001E
`define IR_POWER 16'h001F
`define IR_SUPPLY_CUR 16'h0020
`define IR_LAST 16'h0020

// reset values
`define RST_BAUD 16'h0060
`define RST_ZERO 16'h0000

// allowed values
`define BAUD_9K6 16'h0060
`define BAUD_19K2 16'h00C0
`define BAUD_38K4 16'h0180
`define BAUD_57K6 16'h0240
`define FRAMING_MAX 16'h0002
`define LOOP_REF_MAX 16'h0064
`define GAIN_MAX 16'h7FFF
`define SILENCE_MAX_S 16'h8078

// selector codes
`define INPUT_TYPE_PID_FIXED 16'h000C
`define DOUT_ALARM 16'h0001
`define DOUT_THRESHOLD 16'h0002
`define DOUT_RANGE 16'h0003

// fault code pairs
`define FAULT_PRI_AUTO 16'h0004
`define FAULT_SEC_OVERTEMP 16'h0071
`define FAULT_SEC_LINK_LOST 16'h00FF

// answer exception codes
`define EXC_NONE 8'h00
`define EXC_BAD_ADDR 8'h02
`define EXC_BAD_VALUE 8'h03

// timing
`define CLK_PERIOD_NS 100
`define SECOND_NS 1000000000
`define RAMP_TICK_NS 1000000
`define DERATE_LIMIT_S 16'h001E

`endif

// [src/fan_drive_pkg.sv]
// types shared by the fan drive register map
package fan_drive_pkg;

  typedef enum logic [0:0] {
    RAMP_IDLE,
    RAMP_RUN
  } ramp_state_t;

  typedef struct packed {
    logic [15:0] baud;
    logic [15:0] framing;
    logic [15:0] loop_ref;
    logic [15:0] gain_p;
    logic [15:0] gain_i;
    logic [15:0] gain_d;
    logic [15:0] period;
    logic [15:0] speed_high;
    logic [15:0] silence;
    logic rsp_valid;
    logic [7:0] rsp_exc;
    logic [15:0] rsp_data;
    logic [23:0] sec_cnt;
    logic sec_tick;
    logic [15:0] silence_cnt;
    logic link_lost;
    logic [15:0] ms_cnt;
    ramp_state_t ramp;
    logic [15:0] speed_ref;
    logic derate;
    logic [15:0] derate_sec;
    logic overtemp;
    logic speed_over;
    logic loop_ref_active;
    logic fan_stop;
    logic [15:0] fault_pri;
    logic [15:0] fault_sec;
    logic dout;
  } state_t;

endpackage

// [dv/fan_drive_checker_assertions.sv]
// port assertions of the fan drive register map
`timescale 1ns/10ps
`include "fan_drive_regs.svh"
module fan_drive_checker (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // requests and answers
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_holding_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic reset_cmd_i,
  input wire logic rsp_valid_o,
  input wire logic [7:0] rsp_exc_o,
  // settings and measurements
  input wire logic [15:0] input_type_i,
  input wire logic [15:0] dout_func_i,
  input wire logic [15:0] speed_min_i,
  input wire logic [15:0] temp_limit_i,
  input wire logic [15:0] stage_temp_i,
  input wire logic run_i,
  // results
  input wire logic [15:0] baud_sel_o,
  input wire logic [15:0] framing_sel_o,
  input wire logic [15:0] gain_p_o,
  input wire logic loop_ref_active_o,
  input wire logic [15:0] speed_ref_o,
  input wire logic speed_over_o,
  input wire logic derate_o,
  input wire logic fan_stop_o,
  input wire logic [15:0] fault_sec_o,
  input wire logic dout_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  chk_rsp_next: assert property (req_valid_i |=> rsp_valid_o)
    else $error("no answer after request");
  chk_rsp_no_spur: assert property (rsp_valid_o |-> $past(req_valid_i))
    else $error("answer without request");
  chk_baud_codes: assert property (baud_sel_o inside {16'h0060, 16'h00C0, 16'h0180, 16'h0240})
    else $error("baud code outside the four rates");
  chk_framing_max: assert property (framing_sel_o <= `FRAMING_MAX)
    else $error("framing code above two");
  chk_gain_refused: assert property (req_valid_i && req_write_i && req_holding_i && req_addr_i == `HR_GAIN_P
    && req_wdata_i > `GAIN_MAX |=> rsp_exc_o == `EXC_BAD_VALUE && $stable(gain_p_o))
    else $error("oversize gain not refused or gain changed");
  chk_ref_type: assert property (input_type_i == `INPUT_TYPE_PID_FIXED |=> loop_ref_active_o)
    else $error("fixed reference loop not selected");
  chk_hot_derates: assert property (stage_temp_i > temp_limit_i |=> derate_o)
    else $error("no derating while hot");
  chk_cool_clears: assert property (stage_temp_i < temp_limit_i |=> !derate_o
    && fault_sec_o != `FAULT_SEC_OVERTEMP)
    else $error("thermal state kept after cooling");
  chk_link_stop_holds: assert property (fan_stop_o && fault_sec_o == `FAULT_SEC_LINK_LOST && !reset_cmd_i
    |=> fan_stop_o)
    else $error("link stop released without reset command");
  chk_ramp_start: assert property ($rose(run_i) && !fan_stop_o |=> speed_ref_o == speed_min_i)
    else $error("speed reference did not start at minimum");
  chk_dout_thresh: assert property ($past(dout_func_i) == `DOUT_THRESHOLD |-> dout_o == speed_over_o)
    else $error("output does not follow speed over threshold");
  cov_refused: cover property (rsp_valid_o && rsp_exc_o == `EXC_BAD_VALUE);
  cov_link_lost: cover property ($rose(fan_stop_o) && fault_sec_o == `FAULT_SEC_LINK_LOST);
  cov_overtemp: cover property (fan_stop_o && fault_sec_o == `FAULT_SEC_OVERTEMP);
endmodule // fan_drive_checker

bind fan_drive_modbus_register_map fan_drive_checker chk (.*);

// [dv/modbus_master_model.sv]
// modbus master model issuing decoded requests to the fan drive register map
`timescale 1ns/10ps
`include "fan_drive_regs.svh"
module modbus_master_model #(
  parameter bit ISOLATED = 1'b0
) (
  // clock
  input wire logic clk_sys_i,
  // requests
  output logic req_valid_o,
  output logic req_write_o,
  output logic req_holding_o,
  output logic [15:0] req_addr_o,
  output logic [15:0] req_wdata_o,
  output logic reset_cmd_o,
  // answers
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_exc_i,
  input wire logic [15:0] rsp_data_i
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_holding_o = 1'b0;
    req_addr_o = 16'h5A5A;
    req_wdata_o = 16'hA5A5;
    reset_cmd_o = 1'b0;
  end
  // one request pulse; the answer is taken at a falling edge while it stands
  task automatic xfer(input logic w, input logic h, input logic [15:0] a, input logic [15:0] d,
    output logic [7:0] exc, output logic [15:0] data);
    int n;
    // the isolated terminal cannot carry the two fast rates
    if (ISOLATED && w && h && a == `HR_BAUD && d > `BAUD_19K2) begin
      d = `BAUD_19K2;
    end
    exc = 8'hEE;
    data = 16'h0000;
    n = 0;
    @(negedge clk_sys_i);
    req_valid_o = 1'b1;
    req_write_o = w;
    req_holding_o = h;
    req_addr_o = a;
    req_wdata_o = d;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    req_valid_o = 1'b0;
    // released lines show the inverse so a stale value never passes for a live one
    req_addr_o = ~a;
    req_wdata_o = ~d;
    while (n < 3) begin
      n++;
      if (rsp_valid_i) begin
        exc = rsp_exc_i;
        data = rsp_data_i;
        n = 3;
      end
      @(negedge clk_sys_i);
    end
  endtask
  task automatic send_reset();
    @(negedge clk_sys_i);
    reset_cmd_o = 1'b1;
    @(negedge clk_sys_i);
    reset_cmd_o = 1'b0;
  endtask
  // the fault pair only means something when read together
  task automatic read_pair(output logic [15:0] pri, output logic [15:0] sec);
    logic [7:0] e;
    xfer(1'b0, 1'b0, `IR_FAULT_PRI, 16'h0000, e, pri);
    xfer(1'b0, 1'b0, `IR_FAULT_SEC, 16'h0000, e, sec);
  endtask
endmodule // modbus_master_model

// [dv/fan_drive_modbus_register_map_tb_top.sv]
// self-checking testbench of the fan drive register map
`timescale 1ns/10ps
`include "fan_drive_regs.svh"
module fan_drive_modbus_register_map_tb_top;
  // short second and ramp tick keep supervision waits brief
  localparam int SEC = 20;
  localparam logic [15:0] MADDR [10] = '{`IR_DC_LINK, `IR_WIND_CURRENT, `IR_WIND_VOLTAGE, `IR_SETP_VOLTS,
    `IR_STAGE_TEMP, `IR_RUN_RAW, `IR_SETP_RAW, `IR_SENSOR_RAW, `IR_POWER, `IR_SUPPLY_CUR};
  logic clk_sys_i, rst_i, req_valid_i, req_write_i, req_holding_i, reset_cmd_i, run_i, rsp_valid_o;
  logic [15:0] req_addr_i, req_wdata_i, rsp_data_o, input_type_i, dout_func_i, speed_low_i, speed_max_i;
  logic [15:0] speed_min_i, temp_limit_i, speed_goal_i, ramp_step_i, rotor_speed_i, fault_pri_i, fault_sec_i;
  logic [15:0] baud_sel_o, framing_sel_o, loop_ref_o, gain_p_o, gain_i_o, gain_d_o, period_ms_o;
  logic [15:0] speed_ref_o, fault_pri_o, fault_sec_o, rdata;
  logic loop_ref_active_o, speed_over_o, derate_o, fan_stop_o, dout_o;
  logic [7:0] rsp_exc_o, exc;
  logic [15:0] meas [10];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  fan_drive_modbus_register_map #(.SECOND_CYCLES(SEC), .RAMP_TICK_CYCLES(8)) dut (
    .dc_link_i(meas[0]), .wind_current_i(meas[1]), .wind_voltage_i(meas[2]), .setp_volts_i(meas[3]),
    .stage_temp_i(meas[4]), .run_raw_i(meas[5]), .setp_raw_i(meas[6]), .sensor_raw_i(meas[7]),
    .power_i(meas[8]), .supply_current_i(meas[9]), .*);
  modbus_master_model mst (.clk_sys_i, .req_valid_o(req_valid_i), .req_write_o(req_write_i),
    .req_holding_o(req_holding_i), .req_addr_o(req_addr_i), .req_wdata_o(req_wdata_i),
    .reset_cmd_o(reset_cmd_i), .rsp_valid_i(rsp_valid_o), .rsp_exc_i(rsp_exc_o), .rsp_data_i(rsp_data_o));
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic nc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic acc(input logic w, input logic h, input logic [15:0] a, input logic [15:0] d, input logic [7:0] ee);
    mst.xfer(w, h, a, d, exc, rdata);
    check(16'(exc), 16'(ee), "answer code");
  endtask
  task automatic rd(input logic h, input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, h, a, 16'h0000, `EXC_NONE);
    check(rdata, e, "read data");
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] ee);
    acc(1'b1, 1'b1, a, d, ee);
  endtask
  task automatic t_reset();
    check(baud_sel_o, `RST_BAUD, "baud out");
    rd(1'b1, `HR_BAUD, `RST_BAUD);
    rd(1'b1, `HR_FRAMING, `RST_ZERO);
    rd(1'b1, `HR_LOOP_REF, `RST_ZERO);
    for (logic [15:0] a = `HR_GAIN_P; a <= `HR_PERIOD; a++) begin
      rd(1'b1, a, `RST_ZERO);
    end
  endtask
  task automatic t_limits();
    logic [15:0] ad [6] = '{`HR_FRAMING, `HR_LOOP_REF, `HR_GAIN_P, `HR_GAIN_I, `HR_GAIN_D, `HR_PERIOD};
    logic [15:0] mx [6] = '{`FRAMING_MAX, `LOOP_REF_MAX, `GAIN_MAX, `GAIN_MAX, `GAIN_MAX, `GAIN_MAX};
    logic [15:0] bc [4] = '{`BAUD_9K6, `BAUD_19K2, `BAUD_38K4, `BAUD_57K6};
    foreach (ad[i]) begin
      wr(ad[i], mx[i], `EXC_NONE);
      wr(ad[i], mx[i] + 16'h0001, `EXC_BAD_VALUE);
      rd(1'b1, ad[i], mx[i]);
    end
    foreach (bc[i]) begin
      wr(`HR_BAUD, bc[i], `EXC_NONE);
      nc(1);
      check(baud_sel_o, bc[i], "baud out");
    end
    wr(`HR_BAUD, 16'h0064, `EXC_BAD_VALUE);
    wr(`HR_FRAMING, 16'h0001, `EXC_NONE);
    wr(`HR_FRAMING, 16'h0000, `EXC_NONE);
    nc(1);
    check(baud_sel_o, `BAUD_57K6, "baud kept");
    check(framing_sel_o, 16'h0000, "framing out");
    check(loop_ref_o, `LOOP_REF_MAX, "reference out");
    check(gain_d_o, `GAIN_MAX, "gain out");
    check(gain_i_o, `GAIN_MAX, "gain out");
    check(period_ms_o, `GAIN_MAX, "period out");
  endtask
  task automatic t_inputs();
    logic [15:0] p, s;
    foreach (meas[i]) begin
      rd(1'b0, MADDR[i], meas[i]);
    end
    nc(1);
    foreach (meas[i]) begin
      meas[i] = meas[i] + 16'h0011;
    end
    foreach (meas[i]) begin
      rd(1'b0, MADDR[i], meas[i]);
    end
    rd(1'b0, `IR_ROTOR_SPEED, rotor_speed_i);
    rd(1'b0, 16'h0001, 16'h0000);
    acc(1'b0, 1'b0, 16'h0021, 16'h0000, `EXC_BAD_ADDR);
    acc(1'b1, 1'b0, `IR_ROTOR_SPEED, 16'h0005, `EXC_BAD_ADDR);
    wr(16'h0031, 16'h0000, `EXC_BAD_ADDR);
    nc(1);
    fault_pri_i = 16'h0003;
    mst.read_pair(p, s);
    check(p, 16'h0003, "fault first");
    check(s, 16'h0000, "fault second");
    nc(1);
    fault_pri_i = 16'h0000;
    input_type_i = `INPUT_TYPE_PID_FIXED;
    nc(2);
    check(16'(loop_ref_active_o), 16'h0001, "loop active");
    input_type_i = 16'h000B;
    nc(2);
    check(16'(loop_ref_active_o), 16'h0000, "loop inactive");
  endtask
  task automatic t_thresh();
    wr(`HR_SPEED_HIGH, 16'h0000, `EXC_NONE);
    nc(2);
    check(16'(speed_over_o), 16'h0000, "zero threshold");
    wr(`HR_SPEED_HIGH, 16'h07CF, `EXC_NONE);
    nc(2);
    check(16'(speed_over_o), 16'h0001, "over");
    check(16'(dout_o), 16'h0001, "output over");
    rotor_speed_i = 16'h07CF;
    nc(2);
    check(16'(speed_over_o), 16'h0000, "at threshold");
    check(16'(dout_o), 16'h0000, "output at");
    wr(`HR_SPEED_HIGH, 16'h0BB9, `EXC_BAD_VALUE);
    nc(1);
    dout_func_i = `DOUT_RANGE;
    wr(`HR_SPEED_HIGH, 16'h0190, `EXC_BAD_VALUE);
    wr(`HR_SPEED_HIGH, 16'h01F4, `EXC_NONE);
    nc(1);
    dout_func_i = `DOUT_THRESHOLD;
  endtask
  task automatic t_timeout();
    logic [15:0] p, s;
    wr(`HR_SILENCE, 16'h8079, `EXC_BAD_VALUE);
    wr(`HR_SILENCE, `SILENCE_MAX_S, `EXC_NONE);
    wr(`HR_SILENCE, 16'h0002, `EXC_NONE);
    nc(30);
    check(16'(fan_stop_o), 16'h0000, "early stop");
    nc(25);
    check(16'(fan_stop_o), 16'h0001, "silence stop");
    mst.read_pair(p, s);
    check(p, `FAULT_PRI_AUTO, "fault first");
    check(s, `FAULT_SEC_LINK_LOST, "fault second");
    wr(`HR_SILENCE, 16'h0000, `EXC_NONE);
    nc(5);
    check(16'(fan_stop_o), 16'h0001, "stop held");
    mst.send_reset();
    nc(2);
    check(16'(fan_stop_o), 16'h0000, "stop cleared");
    nc(100);
    check(16'(fan_stop_o), 16'h0000, "timeout off");
  endtask
  task automatic t_thermal();
    logic [15:0] p, s;
    meas[4] = 16'h0352;
    nc(2);
    check(16'(derate_o), 16'h0001, "derating");
    nc(550);
    check(16'(fan_stop_o), 16'h0000, "early thermal stop");
    nc(100);
    check(16'(fan_stop_o), 16'h0001, "thermal stop");
    mst.read_pair(p, s);
    check(p, `FAULT_PRI_AUTO, "fault first");
    check(s, `FAULT_SEC_OVERTEMP, "fault second");
    check(fault_pri_o, `FAULT_PRI_AUTO, "fault out");
    nc(1);
    meas[4] = 16'h0300;
    nc(2);
    check(16'(fan_stop_o), 16'h0000, "cooled stop");
    check(fault_sec_o, 16'h0000, "cooled fault");
  endtask
  task automatic t_ramp();
    run_i = 1'b1;
    nc(1);
    check(speed_ref_o, speed_min_i, "ramp start");
    nc(9);
    check(16'(speed_ref_o > speed_min_i && speed_ref_o < speed_goal_i), 16'h0001, "ramp middle");
    nc(40);
    check(speed_ref_o, speed_goal_i, "ramp end");
    run_i = 1'b0;
    nc(2);
    check(speed_ref_o, 16'h0000, "ramp stopped");
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    rst_i = 1'b1;
    run_i = 1'b0;
    input_type_i = 16'h0001;
    dout_func_i = `DOUT_THRESHOLD;
    speed_low_i = 16'h01F4;
    speed_max_i = 16'h0BB8;
    speed_min_i = 16'h012C;
    temp_limit_i = 16'h0320;
    speed_goal_i = 16'h0154;
    ramp_step_i = 16'h0010;
    rotor_speed_i = 16'h07D0;
    fault_pri_i = 16'h0000;
    fault_sec_i = 16'h0000;
    foreach (meas[i]) begin
      meas[i] = 16'h0100 + 16'(i);
    end
    nc(10);
    rst_i = 1'b0;
    t_reset();
    t_limits();
    t_inputs();
    t_thresh();
    t_timeout();
    t_thermal();
    t_ramp();
    report_and_stop();
  end
endmodule // fan_drive_modbus_register_map_tb_top
